// file: vpc_pkg.sv
// Package: row map, path setup field layout, reset values and enums
package vpc_pkg;
	localparam int ROW_W = 11;
	localparam logic [10:0] SFX_FIRST_ROW = 11'h000;
	localparam logic [10:0] SFX_LAST_ROW = 11'h00F;
	localparam logic [10:0] VOICE_FIRST_ROW = 11'h010;
	localparam logic [10:0] TOP_ROW_SMALL = 11'h0FF;
	localparam logic [10:0] TOP_ROW_LARGE = 11'h78F;
	localparam int CFG_W = 12;
	localparam logic [11:0] PATH_SETUP_RESET = 12'h440;
	localparam int VOL_LSB = 0;
	localparam int MON_BIT = 3;
	localparam int MIX_BIT = 4;
	localparam int EDIT_DIS_BIT = 5;
	localparam int SER_PT_BIT = 6;
	localparam int OUT_SEL_BIT = 7;
	localparam int SPK_DIS_BIT = 8;
	localparam int OUT_OFF_BIT = 9;
	// Serial frame: 8-bit opcode then 16-bit data, MSB first
	localparam int FRAME_BITS = 24;
	localparam logic [7:0] CMD_POWER_UP = 8'h01;
	localparam logic [7:0] CMD_STOP = 8'h02;
	localparam logic [7:0] CMD_RESET = 8'h03;
	localparam logic [7:0] CMD_POWER_DOWN = 8'h07;
	localparam logic [7:0] CMD_PLAY = 8'h40;
	localparam logic [7:0] CMD_REC = 8'h41;
	localparam logic [7:0] CMD_ERASE = 8'h42;
	localparam logic [7:0] CMD_FWD = 8'h48;
	localparam logic [7:0] CMD_RD_SETUP = 8'h44;
	localparam logic [7:0] CMD_WR_SETUP = 8'h45;
	localparam logic [7:0] CMD_STORE_SETUP = 8'h65;
	localparam logic [7:0] CMD_SET_PLAY = 8'h80;
	localparam logic [7:0] CMD_SET_REC = 8'h81;
	localparam logic [7:0] CMD_SET_ERASE = 8'h82;
	typedef enum logic [2:0] {OP_IDLE, OP_REC, OP_PLAY, OP_ERASE, OP_FWD}
		vpc_op_t;
	typedef enum logic [2:0] {SRC_NONE, SRC_AUX, SRC_MIC, SRC_MIC_AUX}
		vpc_src_t;
	// Row range check shared by both control paths
	function automatic logic vpc_row_ok(input logic [10:0] row,
		input logic [10:0] top);
		vpc_row_ok = (row <= top);
	endfunction
endpackage

// file: vpc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module vpc_sync
	#(parameter int W = 1)
	(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
	);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;
	// First stage feeds only the second
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			q_reg <= '0;
		end
		else
		begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end
	assign q = q_reg;
endmodule

// file: vpc_serial.sv
// Serial frame receiver/shifter on sampled link clock edges
`timescale 1ns/10ps
module vpc_serial
	import vpc_pkg::*;
	(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic sel_n_s,
	input wire logic sclk_s,
	input wire logic mosi_s,
	input wire logic [15:0] reply,
	output logic miso,
	output logic frame_done,
	output logic [7:0] opcode,
	output logic [15:0] data
	);
	logic sclk_d_reg;
	logic [23:0] sh_reg, sh_next;
	logic [15:0] out_reg, out_next;
	logic [4:0] cnt_reg, cnt_next;
	logic [7:0] op_reg, op_next;
	logic [15:0] dat_reg, dat_next;
	logic done_reg, done_next;
	logic rise, fall;
	assign rise = sclk_s & ~sclk_d_reg;
	assign fall = ~sclk_s & sclk_d_reg;
	// Shift on rising edges, present reply on falling; frame ends on deselect
	always_comb
	begin
		sh_next = sh_reg;
		out_next = out_reg;
		cnt_next = cnt_reg;
		op_next = op_reg;
		dat_next = dat_reg;
		done_next = 1'b0;
		if (sel_n_s)
		begin
			// Short frames are dropped, not executed
			if (cnt_reg == 5'(FRAME_BITS))
			begin
				op_next = sh_reg[23:16];
				dat_next = sh_reg[15:0];
				done_next = 1'b1;
			end
			cnt_next = '0;
			out_next = reply;
		end
		else
		begin
			if (rise && cnt_reg != 5'(FRAME_BITS))
			begin
				sh_next = {sh_reg[22:0], mosi_s};
				cnt_next = cnt_reg + 5'd1;
			end
			if (fall && cnt_reg >= 5'd8)
				out_next = {out_reg[14:0], 1'b0};
		end
	end
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_d_reg <= 1'b0;
			sh_reg <= '0;
			out_reg <= '0;
			cnt_reg <= '0;
			op_reg <= '0;
			dat_reg <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			sclk_d_reg <= sclk_s;
			sh_reg <= sh_next;
			out_reg <= out_next;
			cnt_reg <= cnt_next;
			op_reg <= op_next;
			dat_reg <= dat_next;
			done_reg <= done_next;
		end
	end
	assign miso = out_reg[15];
	assign frame_done = done_reg;
	assign opcode = op_reg;
	assign data = dat_reg;
endmodule

// file: vpc_top.sv
// Voice path setup register, row map checks and mode control
`timescale 1ns/10ps
module vpc_top
	import vpc_pkg::*;
	(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [10:0] top_row,
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic rec_key_n,
	input wire logic play_key_n,
	input wire logic erase_key_n,
	input wire logic skip_key_n,
	input wire logic reset_key_n,
	input wire logic passthrough_ctrl_n,
	output logic serial_mode,
	output logic [2:0] active_op,
	output logic [10:0] op_row,
	output logic op_row_bad,
	output logic [2:0] record_source,
	output logic monitor_on,
	output logic passthrough_on,
	output logic [2:0] loudness,
	output logic effect_edit_disable,
	output logic aux_out_sel,
	output logic speaker_off,
	output logic out_driver_off,
	output logic [11:0] stored_default_bits
	);
	logic [10:0] sync_in, sync_out;
	logic sel_n_s, sclk_s, mosi_s;
	logic rec_s, play_s, erase_s, skip_s, rst_key_s, pt_pin_s;
	logic frame_done;
	logic [7:0] opcode;
	logic [15:0] cmd_data;
	logic [15:0] reply;
	logic [11:0] analog_path_setup_reg, analog_path_setup_next;
	logic [11:0] stored_reg, stored_next;
	logic serial_reg, serial_next;
	vpc_op_t op_reg, op_next;
	logic [10:0] row_reg, row_next;
	logic [10:0] sa_row_reg, sa_row_next;
	logic key_prev_reg;
	logic keys_any;
	logic passthrough;
	vpc_src_t src;
	// Registered path outputs and their next values
	vpc_src_t src_out_reg, src_out_next;
	logic mon_reg, mon_next;
	logic pt_on_reg, pt_on_next;
	logic bad_reg, bad_next;
	logic [10:0] slot_inc;

	// Every pin goes through two flops before use. Active-low pins are
	// inverted first, so the cleared flops read as idle pins: no false
	// select, key press or passthrough in the cycles after reset.
	assign sync_in = {~sel_n, sclk, mosi, ~rec_key_n, ~play_key_n,
		~erase_key_n, ~skip_key_n, ~reset_key_n, ~passthrough_ctrl_n,
		2'b00};
	vpc_sync #(.W(11)) u_sync
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d(sync_in),
		.q(sync_out)
	);
	assign sel_n_s = ~sync_out[10];
	assign sclk_s = sync_out[9];
	assign mosi_s = sync_out[8];
	assign rec_s = sync_out[7];
	assign play_s = sync_out[6];
	assign erase_s = sync_out[5];
	assign skip_s = sync_out[4];
	assign rst_key_s = sync_out[3];
	assign pt_pin_s = sync_out[2];

	// Readback reply: path setup content, in the low twelve bits
	assign reply = {4'h0, analog_path_setup_reg};
	vpc_serial u_serial
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.sel_n_s(sel_n_s),
		.sclk_s(sclk_s),
		.mosi_s(mosi_s),
		.reply(reply),
		.miso(miso),
		.frame_done(frame_done),
		.opcode(opcode),
		.data(cmd_data)
	);
	// Drive the data-out pin only while selected
	assign miso_oe = ~sel_n_s;

	assign keys_any = rec_s | play_s | erase_s | skip_s;
	// Candidate next slot, checked against the capacity top row; the
	// wrap keeps standalone messages out of the effect rows
	assign slot_inc = sa_row_reg + 11'd1;

	// Command and key decode; a key starts only after the last ends, a command replaces any op at once
	always_comb
	begin
		analog_path_setup_next = analog_path_setup_reg;
		stored_next = stored_reg;
		serial_next = serial_reg;
		op_next = op_reg;
		row_next = row_reg;
		sa_row_next = sa_row_reg;
		if (frame_done)
		begin
			case (opcode)
				CMD_POWER_UP: serial_next = 1'b1;
				CMD_POWER_DOWN:
				begin
					serial_next = 1'b0;
					op_next = OP_IDLE;
				end
				CMD_STOP: op_next = OP_IDLE;
				CMD_RESET:
				begin
					analog_path_setup_next = stored_reg;
					op_next = OP_IDLE;
				end
				// Only affects paths, never the stored copy
				CMD_WR_SETUP:
					analog_path_setup_next = cmd_data[11:0];
				CMD_STORE_SETUP:
					stored_next = analog_path_setup_reg;
				CMD_RD_SETUP: op_next = op_reg;
				CMD_PLAY: if (serial_reg) op_next = OP_PLAY;
				CMD_REC: if (serial_reg) op_next = OP_REC;
				CMD_ERASE: if (serial_reg) op_next = OP_ERASE;
				CMD_FWD: if (serial_reg) op_next = OP_FWD;
				CMD_SET_PLAY, CMD_SET_REC, CMD_SET_ERASE:
				begin
					// Direct eleven-bit row access, any row in range
					if (serial_reg)
					begin
						row_next = cmd_data[10:0];
						if (opcode == CMD_SET_PLAY)
							op_next = OP_PLAY;
						else if (opcode == CMD_SET_REC)
							op_next = OP_REC;
						else
							op_next = OP_ERASE;
					end
				end
				default: op_next = op_reg;
			endcase
		end
		else if (!serial_reg)
		begin
			// Standalone: keys pick the op, device manages rows itself
			if (rst_key_s)
			begin
				analog_path_setup_next = stored_reg;
				sa_row_next = VOICE_FIRST_ROW;
				op_next = OP_IDLE;
			end
			else if (!keys_any)
				op_next = OP_IDLE;
			else if (!key_prev_reg)
			begin
				if (rec_s)
					op_next = OP_REC;
				else if (play_s)
					op_next = OP_PLAY;
				else if (erase_s)
					op_next = OP_ERASE;
				else
					op_next = OP_FWD;
				row_next = sa_row_reg;
				// Next message slot wraps to voice start past top row
				if (vpc_row_ok(slot_inc, top_row))
					sa_row_next = slot_inc;
				else
					sa_row_next = VOICE_FIRST_ROW;
			end
		end
	end

	// Stored bits reset to factory value; model of the nonvolatile copy
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			analog_path_setup_reg <= PATH_SETUP_RESET;
			stored_reg <= PATH_SETUP_RESET;
			serial_reg <= 1'b0;
			op_reg <= OP_IDLE;
			row_reg <= VOICE_FIRST_ROW;
			sa_row_reg <= VOICE_FIRST_ROW;
			key_prev_reg <= 1'b0;
		end
		else
		begin
			analog_path_setup_reg <= analog_path_setup_next;
			stored_reg <= stored_next;
			serial_reg <= serial_next;
			op_reg <= op_next;
			row_reg <= row_next;
			sa_row_reg <= sa_row_next;
			key_prev_reg <= keys_any;
		end
	end

	// Passthrough control: setup bit in serial mode, pin otherwise (0 = on).
	// Built from next values so the registered path outputs below change
	// on the same edge as active_op, never a cycle behind it.
	assign passthrough = serial_next ?
		~analog_path_setup_next[SER_PT_BIT] : pt_pin_s;

	// Source from mix bit and the raw control level, where low means on
	always_comb
	begin
		case ({analog_path_setup_next[MIX_BIT], ~passthrough})
			2'b00: src = SRC_AUX;
			2'b11: src = SRC_MIC;
			2'b10: src = SRC_MIC_AUX;
			2'b01: src = SRC_MIC;
			default: src = SRC_NONE;
		endcase
	end

	// Path outputs for the operation that starts on the coming edge
	always_comb
	begin
		src_out_next = SRC_NONE;
		mon_next = 1'b0;
		if (op_next == OP_REC)
		begin
			src_out_next = src;
			mon_next = analog_path_setup_next[MON_BIT];
		end
		pt_on_next = passthrough & (op_next != OP_PLAY);
		// Effect rows are legal targets too; only past-top is flagged
		bad_next = ~vpc_row_ok(row_next, top_row);
	end

	// Data outputs come from flops; a few extra flops buy glitch-free
	// levels for the analog switches that these outputs steer
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src_out_reg <= SRC_NONE;
			mon_reg <= 1'b0;
			pt_on_reg <= 1'b0;
			bad_reg <= 1'b0;
		end
		else
		begin
			src_out_reg <= src_out_next;
			mon_reg <= mon_next;
			pt_on_reg <= pt_on_next;
			bad_reg <= bad_next;
		end
	end

	assign serial_mode = serial_reg;
	assign active_op = op_reg;
	assign op_row = row_reg;
	assign op_row_bad = bad_reg;
	assign record_source = src_out_reg;
	assign monitor_on = mon_reg;
	assign passthrough_on = pt_on_reg;
	assign loudness = analog_path_setup_reg[VOL_LSB +: 3];
	assign effect_edit_disable = analog_path_setup_reg[EDIT_DIS_BIT];
	assign aux_out_sel = analog_path_setup_reg[OUT_SEL_BIT];
	assign speaker_off = analog_path_setup_reg[SPK_DIS_BIT];
	assign out_driver_off = analog_path_setup_reg[OUT_OFF_BIT];
	assign stored_default_bits = stored_reg;
endmodule

// file: vpc_props.sv
// Checker: port relations of the path setup block
`timescale 1ns/10ps
module vpc_props
	import vpc_pkg::*;
	(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [10:0] top_row,
	input wire logic sel_n,
	input wire logic reset_key_n,
	input wire logic miso_oe,
	input wire logic serial_mode,
	input wire logic [2:0] active_op,
	input wire logic [10:0] op_row,
	input wire logic op_row_bad,
	input wire logic [2:0] record_source,
	input wire logic [2:0] loudness,
	input wire logic [11:0] stored_default_bits
	);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// A source is chosen only while recording
	a_src_idle: assert property (
		active_op != OP_REC |-> record_source == SRC_NONE)
		else $error("source outside record");
	a_src_rec: assert property (
		active_op == OP_REC |-> record_source != SRC_NONE)
		else $error("no source in record");
	a_row_flag: assert property (
		op_row_bad == (op_row > top_row))
		else $error("row flag wrong");
	// Commands act only after the frame closes, never mid-shift
	a_store_cause: assert property (
		$changed(stored_default_bits) |-> sel_n && $past(sel_n, 2))
		else $error("stored bits changed mid frame");
	a_mode_cause: assert property (
		$changed(serial_mode) |-> sel_n && $past(sel_n, 2))
		else $error("mode changed mid frame");
	// Reset key is the only other way to reload the setup
	a_vol_cause: assert property (
		$changed(loudness) |-> sel_n && $past(sel_n, 2) || !reset_key_n)
		else $error("loudness changed without cause");
	a_oe_off: assert property (
		sel_n [*4] |-> !miso_oe)
		else $error("data out driven unselected");
	a_oe_on: assert property (
		!sel_n [*4] |-> miso_oe)
		else $error("data out idle while selected");
	cover property (active_op == OP_REC && record_source == SRC_MIC_AUX);
	cover property ($rose(serial_mode));
	cover property ($changed(stored_default_bits));
endmodule
bind vpc_top vpc_props u_props (.core_clk, .rst_n, .top_row, .sel_n,
	.reset_key_n, .miso_oe, .serial_mode, .active_op, .op_row,
	.op_row_bad, .record_source, .loudness, .stored_default_bits);

// file: vpc_host.sv
// Controller model driving the serial link
`timescale 1ns/10ps
module vpc_host
	(
	output logic sel_n,
	output logic sclk,
	output logic mosi,
	input wire logic miso
	);
	// Link clock stands low between frames
	initial
	begin
		sel_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b1;
	end
	// Reply sampled late in each bit to clear the device's sampling lag
	task automatic xfer(input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] r);
		r = 16'h0000;
		sel_n = 1'b0;
		for (int i = 0; i < 24; i++)
		begin
			mosi = i < 8 ? c[7 - i] : d[23 - i];
			#160 sclk = 1'b1;
			// Reply MSB stands from the last opcode bit on
			#160 if (i > 6 && i < 23) r = {r[14:0], miso};
			sclk = 1'b0;
		end
		#160 sel_n = 1'b1;
		mosi = ~mosi; // Released line shows no stale bit
		#480;
	endtask
endmodule

// file: test_voice_path_config_and_row_map.sv
// Bench: serial and key scenarios for the path setup block
`timescale 1ns/10ps
module test_voice_path_config_and_row_map
	import vpc_pkg::*;
	;
	logic core_clk, rst_n, sel_n, sclk, mosi, miso, rkey_n, ft_n;
	logic [3:0] keys_n;
	logic [2:0] op, src, loud;
	logic [10:0] row;
	logic [11:0] stored;
	logic [15:0] rd;
	logic mode, bad, mon, pt, edit, aux, spk, drv;
	int n_fail = 0;
	int tests_run = 0;
	wire logic [6:0] fld = {drv, spk, aux, edit, loud};
	vpc_top dut (.core_clk, .rst_n, .top_row(TOP_ROW_SMALL), .sel_n,
		.sclk, .mosi, .miso, .miso_oe(), .rec_key_n(keys_n[0]),
		.play_key_n(keys_n[1]), .erase_key_n(keys_n[2]),
		.skip_key_n(keys_n[3]), .reset_key_n(rkey_n),
		.passthrough_ctrl_n(ft_n), .serial_mode(mode), .active_op(op),
		.op_row(row), .op_row_bad(bad), .record_source(src),
		.monitor_on(mon), .passthrough_on(pt), .loudness(loud),
		.effect_edit_disable(edit), .aux_out_sel(aux),
		.speaker_off(spk), .out_driver_off(drv),
		.stored_default_bits(stored));
	vpc_host host (.sel_n, .sclk, .mosi, .miso);
	task automatic chk(input string s, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cmd(input logic [7:0] c, input logic [15:0] d);
		@(negedge core_clk);
		host.xfer(c, d, rd);
	endtask
	// Setup fields visible at the ports
	function automatic logic [6:0] fexp(input logic [11:0] w);
		return {w[9], w[8], w[7], w[5], w[2:0]};
	endfunction
	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic t_reset;
		chk("stored", 12'h440, stored);
		chk("fields", fexp(12'h440), fld);
		cmd(CMD_RD_SETUP, 16'h0000);
		chk("readback", 12'h440, rd[11:0]);
		$display("reset test done");
	endtask
	// All loudness steps; stored bits must not follow writes
	task automatic t_write;
		logic [11:0] w;
		cmd(CMD_POWER_UP, 16'h0000);
		chk("mode", 1'b1, mode);
		for (int v = 0; v < 8; v++)
		begin
			w = {2'b00, {3{v[0]}}, 1'b0, v[1], 2'b00, v[2:0]};
			cmd(CMD_WR_SETUP, {4'h0, w});
			chk("fields", fexp(w), fld);
			chk("stored", 12'h440, stored);
			cmd(CMD_RD_SETUP, 16'h0000);
			chk("readback", w, rd[11:0]);
		end
		$display("write test done");
	endtask
	task automatic t_source;
		vpc_src_t se [4] = '{SRC_AUX, SRC_MIC_AUX, SRC_MIC, SRC_MIC};
		logic [10:0] rw [4] = '{11'h0FF, 11'h100, 11'h7FF, 11'h010};
		for (int k = 0; k < 4; k++)
		begin
			cmd(CMD_WR_SETUP, {9'h000, k[1], 1'b0, k[0], k[0], 3'b000});
			chk("passthrough", !k[1], pt);
			cmd(CMD_SET_REC, {5'h00, rw[k]});
			chk("source", se[k], src);
			chk("monitor", k[0], mon);
			chk("row", rw[k], row);
			chk("row flag", rw[k] > TOP_ROW_SMALL, bad);
			cmd(CMD_STOP, 16'h0000);
			chk("op", OP_IDLE, op);
		end
		$display("source test done");
	endtask
	task automatic t_ops;
		logic [7:0] cs [6] = '{CMD_PLAY, CMD_REC, CMD_ERASE, CMD_FWD,
			CMD_SET_PLAY, CMD_SET_ERASE};
		vpc_op_t os [6] = '{OP_PLAY, OP_REC, OP_ERASE, OP_FWD, OP_PLAY,
			OP_ERASE};
		for (int i = 0; i < 6; i++)
		begin
			cmd(cs[i], 16'h0010);
			chk("op", os[i], op);
			cmd(CMD_STOP, 16'h0000);
		end
		$display("ops test done");
	endtask
	task automatic t_store;
		cmd(CMD_WR_SETUP, 16'h02A5);
		cmd(CMD_STORE_SETUP, 16'h0000);
		chk("stored", 12'h2A5, stored);
		cmd(CMD_WR_SETUP, 16'h0003);
		chk("stored", 12'h2A5, stored);
		cmd(CMD_RESET, 16'h0000);
		chk("fields", fexp(12'h2A5), fld);
		cmd(CMD_WR_SETUP, 16'h0007);
		$display("store test done");
	endtask
	// Serial ops refused after power-down; keys then run the device
	task automatic t_keys;
		vpc_op_t ko [4] = '{OP_REC, OP_PLAY, OP_ERASE, OP_FWD};
		cmd(CMD_POWER_DOWN, 16'h0000);
		cmd(CMD_PLAY, 16'h0010);
		chk("op", OP_IDLE, op);
		for (int k = 0; k < 4; k++)
		begin
			keys_n[k] = 1'b0;
			repeat (8) @(negedge core_clk);
			chk("key op", ko[k], op);
			chk("slot row", 16'(VOICE_FIRST_ROW + k), row);
			if (k == 0)
				chk("source", SRC_MIC, src);
			keys_n[k] = 1'b1;
			repeat (8) @(negedge core_clk);
		end
		// Pin passthrough on in standalone mode: aux is recorded
		ft_n = 1'b0;
		keys_n[0] = 1'b0;
		repeat (8) @(negedge core_clk);
		chk("passthrough", 1'b1, pt);
		chk("source", SRC_AUX, src);
		keys_n[0] = 1'b1;
		ft_n = 1'b1;
		repeat (8) @(negedge core_clk);
		rkey_n = 1'b0;
		repeat (10) @(negedge core_clk);
		rkey_n = 1'b1;
		chk("fields", fexp(12'h2A5), fld);
		$display("key test done");
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// Whole run needs about 0.41 milliseconds
	initial
	begin
		#2000000;
		n_fail++;
		test_done;
	end
	initial
	begin
		rst_n = 1'b0;
		keys_n = 4'hF;
		rkey_n = 1'b1;
		ft_n = 1'b1;
		repeat (12) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		t_reset;
		t_write;
		t_source;
		t_ops;
		t_store;
		t_keys;
		test_done;
	end
endmodule
